// file: trf_recal_filter.sv
/*
  Temperature recalibration request filter: three registers on the global
  address space, an out-of-range filter counter and the request flag.
  A small word register module serves both limit registers.
  Assumes temp_valid/temp_result come from logic on clk, and that the
  flag clear and interrupt enable come from the status/control registers
  kept elsewhere.
*/
`timescale 1ns/1ps
module trf_recal_filter #(
  parameter int unsigned TEMP_WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [trf_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_word,
  input wire logic [trf_pkg::DATA_W-1:0] bus_wdata,
  output logic [trf_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic temp_valid,
  input wire logic [TEMP_WIDTH-1:0] temp_result,
  input wire logic recal_flag_clear,
  input wire logic recal_irq_enable,
  output logic recal_request_flag,
  output logic recal_irq,
  output logic [trf_pkg::PERIOD_W-1:0] filter_count
);
  import trf_pkg::*;

  logic [PERIOD_W-1:0] filter_period_count_reg;
  logic [PERIOD_W-1:0] filter_period_count_next;
  logic [TEMP_WIDTH-1:0] upper_temp_limit_reg;
  logic [TEMP_WIDTH-1:0] lower_temp_limit_reg;
  logic [PERIOD_W-1:0] count_reg;
  logic [PERIOD_W-1:0] count_next;
  logic flag_reg;
  logic flag_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rvalid_reg;

  // address window decode
  wire in_blocking = bus_addr[ADDR_W-1:PAGE_W] ==
    BASE_BLOCKING[ADDR_W-1:PAGE_W];
  wire in_nonblocking = bus_addr[ADDR_W-1:PAGE_W] ==
    BASE_NONBLOCKING[ADDR_W-1:PAGE_W];
  wire in_window = in_blocking | in_nonblocking;
  wire [PAGE_W-1:0] page_ofs = bus_addr[PAGE_W-1:0];
  wire hit_period = in_window && (page_ofs == OFS_FILTER_PERIOD);
  // both bytes of a limit register decode, but only words act on writes
  wire hit_upper = in_window &&
    (page_ofs[PAGE_W-1:1] == OFS_UPPER_LIMIT[PAGE_W-1:1]);
  wire hit_lower = in_window &&
    (page_ofs[PAGE_W-1:1] == OFS_LOWER_LIMIT[PAGE_W-1:1]);
  wire hi_byte = ~page_ofs[0];

  // period register is byte wide; a word write puts it in the low lane
  wire wr_period = bus_wr && hit_period;
  // byte writes to limits unsupported: ignored rather than half-merged
  wire wr_upper = bus_wr && bus_word && hit_upper && hi_byte;
  wire wr_lower = bus_wr && bus_word && hit_lower && hi_byte;

  wire [PERIOD_W-1:0] period_wr_field =
    bus_wdata[PERIOD_LSB+PERIOD_W-1:PERIOD_LSB];
  assign filter_period_count_next = wr_period ?
    period_wr_field : filter_period_count_reg;

  // read data; words are big-endian, a byte read of a limit
  // returns the addressed lane in the low bits
  wire [DATA_W-1:0] period_rd = {{(DATA_W-PERIOD_W){1'b0}},
    filter_period_count_reg};
  wire [DATA_W-1:0] upper_rd = DATA_W'(upper_temp_limit_reg);
  wire [DATA_W-1:0] lower_rd = DATA_W'(lower_temp_limit_reg);
  wire [DATA_W-1:0] limit_rd = hit_upper ? upper_rd : lower_rd;
  wire [DATA_W-1:0] limit_byte = hi_byte ?
    {8'h00, limit_rd[15:8]} : {8'h00, limit_rd[7:0]};
  wire [DATA_W-1:0] limit_sel = bus_word ? limit_rd : limit_byte;
  assign rdata_next = hit_period ? period_rd :
    (hit_upper || hit_lower) ? limit_sel : 16'h0000;

  // filter: the two comparisons jointly define out-of-range
  wire above_max = temp_result >= upper_temp_limit_reg;
  wire below_min = temp_result < lower_temp_limit_reg;
  wire out_of_range = above_max | below_min;
  wire at_period = count_reg >= filter_period_count_reg;
  wire at_zero = count_reg == RST_FILTER_COUNT;

  always_comb begin
    count_next = count_reg;
    if (temp_valid) begin
      if (out_of_range) begin
        if (!at_period) begin
          count_next = count_reg + 3'h1;
        end
      end else if (!at_zero) begin
        count_next = count_reg - 3'h1;
      end
    end
    // period lowered under the count: clamp so it cannot sit above it
    if (count_next > filter_period_count_reg) begin
      count_next = filter_period_count_reg;
    end
  end

  // detection needs an out-of-range result that lands on the period
  wire detect = temp_valid && out_of_range &&
    (count_next >= filter_period_count_reg);

  // hardware set wins over a same-cycle software clear
  wire flag_drop = recal_flag_clear && !detect;
  assign flag_next = detect ? 1'b1 :
    flag_drop ? 1'b0 : flag_reg;

  // period field alone; its upper bits are never stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filter_period_count_reg <= RST_FILTER_PERIOD;
    end else begin
      filter_period_count_reg <= filter_period_count_next;
    end
  end

  // both limits share one word register shape
  trf_word_reg #(
    .WIDTH(TEMP_WIDTH),
    .RST_VAL(RST_UPPER_LIMIT[TEMP_WIDTH-1:0])
  ) u_upper_limit_reg (
    .clk(clk),
    .rst_b(rst_b),
    .load(wr_upper),
    .d(bus_wdata[TEMP_WIDTH-1:0]),
    .q(upper_temp_limit_reg)
  );

  trf_word_reg #(
    .WIDTH(TEMP_WIDTH),
    .RST_VAL(RST_LOWER_LIMIT[TEMP_WIDTH-1:0])
  ) u_lower_limit_reg (
    .clk(clk),
    .rst_b(rst_b),
    .load(wr_lower),
    .d(bus_wdata[TEMP_WIDTH-1:0]),
    .q(lower_temp_limit_reg)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= RST_FILTER_COUNT;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= bus_rd ? rdata_next : rdata_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= bus_rd;
    end
  end

  assign bus_rdata = rdata_reg;
  assign bus_rvalid = rvalid_reg;
  assign recal_request_flag = flag_reg;
  // level interrupt follows the sticky flag while enabled
  assign recal_irq = flag_reg & recal_irq_enable;
  assign filter_count = count_reg;
endmodule : trf_recal_filter

// word register with load; reset value fixed per instance
module trf_word_reg #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import trf_pkg::*;
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  assign q_next = load ? d : q_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= RST_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : trf_word_reg

// file: trf_pkg.sv
/*
  Shared constants for the temperature recalibration request filter:
  register offsets, address window bases, field layout and reset values.
  Assumes a 16-bit global address space, big-endian byte order.
*/
package trf_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned PERIOD_W = 3;
  localparam int unsigned PAGE_W = 8;
  localparam logic [ADDR_W-1:0] BASE_BLOCKING = 16'h0200;
  localparam logic [ADDR_W-1:0] BASE_NONBLOCKING = 16'h0300;
  localparam logic [PAGE_W-1:0] OFS_FILTER_PERIOD = 8'hA3;
  localparam logic [PAGE_W-1:0] OFS_UPPER_LIMIT = 8'hA4;
  localparam logic [PAGE_W-1:0] OFS_LOWER_LIMIT = 8'hA6;
  localparam int unsigned PERIOD_LSB = 0;
  localparam logic [PERIOD_W-1:0] RST_FILTER_PERIOD = 3'h0;
  localparam logic [TEMP_W-1:0] RST_UPPER_LIMIT = 16'h0000;
  localparam logic [TEMP_W-1:0] RST_LOWER_LIMIT = 16'h0000;
  localparam logic [PERIOD_W-1:0] RST_FILTER_COUNT = 3'h0;
endpackage : trf_pkg

// file: trf_recal_filter_assertions.sv
/* assertions on trf_recal_filter ports
   assumes the bind below reaches each instance */
`timescale 1ns/1ps
module trf_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_rd,
  input wire logic bus_rvalid,
  input wire logic temp_valid,
  input wire logic recal_flag_clear,
  input wire logic recal_irq_enable,
  input wire logic recal_request_flag,
  input wire logic recal_irq,
  input wire logic [trf_pkg::PERIOD_W-1:0] filter_count
);
  import trf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (bus_rd |=> bus_rvalid)
    else $error("read not answered");
  a_rvalid_pulse: assert property (!bus_rd |=> !bus_rvalid)
    else $error("stray read answer");
  a_irq_gated: assert property (
    recal_irq == (recal_request_flag && recal_irq_enable))
    else $error("irq not flag and enable");
  // period writes may clamp; bench only writes at count zero
  a_count_idle: assert property (
    !temp_valid |=> $stable(filter_count)) else $error("count moved");
  a_floor_zero: assert property (
    temp_valid && filter_count == 3'h0 |=> filter_count <= 3'h1)
    else $error("count wrapped");
  a_flag_cause: assert property (
    $rose(recal_request_flag) |-> $past(temp_valid))
    else $error("flag without result");
  a_flag_sticky: assert property (
    recal_request_flag && !recal_flag_clear |=> recal_request_flag)
    else $error("flag dropped");
  a_flag_clear: assert property (
    recal_flag_clear && !temp_valid |=> !recal_request_flag)
    else $error("flag not cleared");
endmodule : trf_chk
bind trf_recal_filter trf_chk u_trf_chk (.clk, .rst_b, .bus_rd,
  .bus_rvalid, .temp_valid, .recal_flag_clear, .recal_irq_enable,
  .recal_request_flag, .recal_irq, .filter_count);

// file: trf_temp_src.sv
/* temperature result source model
   assumes send is called from the bench */
`timescale 1ns/1ps
module trf_temp_src (
  input wire logic clk,
  output logic temp_valid,
  output logic [15:0] temp_result
);
  initial temp_valid = 1'b0;
  initial temp_result = 16'h0000;
  // gap 0 keeps valid high for a back-to-back result
  task automatic send(input logic [15:0] v, input int gap);
    @(negedge clk);
    temp_valid = 1'b1;
    temp_result = v;
    if (gap > 0) begin
      @(negedge clk);
      temp_valid = 1'b0;
      temp_result = ~v;
      repeat (gap - 1) @(negedge clk);
    end
  endtask : send
endmodule : trf_temp_src

// file: trf_recal_filter_tb.sv
/* bench for trf_recal_filter
   assumes the model and checker compile first */
`timescale 1ns/1ps
module trf_recal_filter_tb;
  logic clk = '0, rst_b = '0, bus_wr = '0, bus_rd = '0, bus_word = '0;
  logic recal_flag_clear = '0, recal_irq_enable = '0;
  logic [15:0] bus_addr = '0, bus_wdata = '0, bus_rdata, temp_result;
  logic bus_rvalid, temp_valid, recal_request_flag, recal_irq;
  logic [2:0] filter_count;
  int n_fail = 0, check_count = 0, cyc = 0;
  always #2 clk = ~clk;
  trf_recal_filter u_trf_recal_filter (.clk, .rst_b, .bus_addr, .bus_wr,
    .bus_rd, .bus_word, .bus_wdata, .bus_rdata, .bus_rvalid, .temp_valid,
    .temp_result, .recal_flag_clear, .recal_irq_enable,
    .recal_request_flag, .recal_irq, .filter_count);
  trf_temp_src u_trf_temp_src (.clk, .temp_valid, .temp_result);
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, d, input logic w);
    @(negedge clk);
    {bus_addr, bus_wdata, bus_word, bus_wr} = {a, d, w, 1'b1};
    @(negedge clk);
    bus_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e);
    @(negedge clk);
    {bus_addr, bus_word, bus_rd} = {a, w, 1'b1};
    @(negedge clk);
    bus_rd = 1'b0;
    chk(16'(bus_rvalid), 16'h0001);
    chk(bus_rdata, e);
  endtask : rd
  task automatic st(input logic [2:0] c, input logic f);
    chk(16'(filter_count), 16'(c));
    chk(16'(recal_request_flag), 16'(f));
  endtask : st
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rd(16'h02A3, 1'b1, 16'h0000);
    rd(16'h03A4, 1'b1, 16'h0000);
    wr(16'h03A3, 16'h00FF, 1'b1);
    rd(16'h02A3, 1'b0, 16'h0007);
    wr(16'h02A3, 16'h0002, 1'b0);
    wr(16'h03A4, 16'h0064, 1'b1);
    wr(16'h02A6, 16'h000A, 1'b1);
    wr(16'h02A4, 16'h00FF, 1'b0);
    rd(16'h03A4, 1'b1, 16'h0064);
    rd(16'h02A5, 1'b0, 16'h0064);
    rd(16'h03A6, 1'b1, 16'h000A);
    rd(16'h02A9, 1'b0, 16'h0000);
    $display("test regs done");
    u_trf_temp_src.send(16'h0064, 1);
    st(3'h1, 1'b0);
    u_trf_temp_src.send(16'h0063, 1);
    st(3'h0, 1'b0);
    u_trf_temp_src.send(16'h000A, 1);
    st(3'h0, 1'b0);
    u_trf_temp_src.send(16'h0009, 0);
    u_trf_temp_src.send(16'h0009, 1);
    st(3'h2, 1'b1);
    u_trf_temp_src.send(16'h00C8, 1);
    st(3'h2, 1'b1);
    $display("test filter done");
    recal_irq_enable = 1'b1;
    #1 chk(16'(recal_irq), 16'h0001);
    @(negedge clk);
    recal_flag_clear = 1'b1;
    @(negedge clk);
    recal_flag_clear = 1'b0;
    st(3'h2, 1'b0);
    chk(16'(recal_irq), 16'h0000);
    $display("test flag done");
    end_of_test();
  end
endmodule : trf_recal_filter_tb
